// file: src/sces_pkg.sv
// Purpose: Shared constants and carrier types for the serial channel event status block
// Assumes: One system clock, registers read through a plain read strobe and byte address
// Notes:   Bit positions follow the event status layout for all three protocol modes
package sces_pkg;
	// ==========================================================
	// Register map
	localparam int unsigned ADDR_W = 12;
	localparam logic [ADDR_W-1:0] CHAN_STATUS_OFS [4] = '{12'h158, 12'h1d8, 12'h258, 12'h2d8};
	localparam logic [31:0] STATUS_RST = 32'h0000_0000;
	localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;

	// ==========================================================
	// Event bit positions (shared positions change meaning by mode)
	localparam int unsigned B_ALL_SENT   = 18;
	localparam int unsigned B_UNDERRUN   = 16; // Frame and byte-sync
	localparam int unsigned B_PAUSE_CHAR = 16; // Async
	localparam int unsigned B_TIMER      = 15;
	localparam int unsigned B_CTS_CHANGE = 14;
	localparam int unsigned B_RETRANSMIT = 13; // Frame and byte-sync
	localparam int unsigned B_RESUME_CHR = 13; // Async
	localparam int unsigned B_POOL_READY = 12;
	localparam int unsigned B_BREAK      = 9;
	localparam int unsigned B_BREAK_END  = 8;
	localparam int unsigned B_RX_OVERRUN = 7;  // Frame
	localparam int unsigned B_TERM_CHAR  = 7;  // Async and byte-sync
	localparam int unsigned B_FRAME_STRT = 6;  // Frame
	localparam int unsigned B_TIMEOUT    = 6;  // Async
	localparam int unsigned B_REMOTE_CHG = 5;  // Frame
	localparam int unsigned B_PARITY     = 5;  // Async and byte-sync
	localparam int unsigned B_PROTOCOL   = 4;  // Frame
	localparam int unsigned B_FRAMING    = 4;  // Async
	localparam int unsigned B_SYNC_PAT   = 4;  // Byte-sync
	localparam int unsigned B_UNLOCK     = 3;
	localparam int unsigned B_CARRIER    = 2;
	localparam int unsigned B_FIFO_OVF   = 1;
	localparam int unsigned B_TOO_LONG   = 0;

	// ==========================================================
	// Counts
	localparam logic [2:0] BYTES_FOR_RETX = 3'h4;

	typedef enum logic [1:0] {SCES_FRAME, SCES_ASYNC, SCES_BSYNC} sces_mode_t;

	typedef struct packed {
		sces_mode_t  mode;
		logic        auto_mode;
		logic        parity_enable;
		logic        parity_odd;
		logic        per_char_status_enable;
		logic        inband_flow_enable;
		logic        timeout_enable;
		logic [7:0]  timeout_length;
		logic [3:0]  char_bits;
		logic [1:0]  stop_bits;
		logic [7:0]  pause_char;
		logic [7:0]  resume_char;
		logic [7:0]  term_char;
		logic        masked_visible_option;
		logic        tx_from_clock_recovery_loop;
		logic        addr_recog;
		logic        length_check;
	} sces_cfg_t;

	typedef struct packed {
		logic       valid;
		logic [7:0] data;
		logic       parity_bit;
		logic       stop_bit;
	} sces_rx_char_t;
endpackage

// file: src/sces_event_status.sv
// Purpose: Event status register of one serial channel with its event detection
// Assumes: Protocol engines supply one-cycle event pulses; line inputs are synchronous
// Notes:   Reading the status word collects and clears it; a new event in that cycle survives
// Notes on behaviour
// - Frame mode: all-sent on last bit, or in auto mode on ack, ack timeout
// - Async/byte-sync: all-sent when last char out, FIFO empty
// - Frame underrun: abort, flag, halt until reset
// - Byte-sync underrun: idle, flag, halt until reset
// - Async pause/resume chars flagged, steer transmitter
// - Timer expiry sets timer flag
// - Any CTS edge flags change; level readable
// - Retransmit request after four bytes on fault
// - Pool ready after transmitter reset, clock present
// - Break after char, parity and stop bit times low (no start bit); end on rise
// - Frame overflow: flag, discard, mark status byte
// - Termination char flags and pushes frame end
// - Frame start on address match or flag
// - Async timeout when no character in period
// - Auto mode remote ready/not-ready change flagged
// - Parity error flagged, optionally in status byte
// - Auto mode protocol error on bad frames
// - Framing error on zero stop bit
// - Sync pattern flagged only after hunt command
// - Clock recovery unlock flags, blocks rx, pauses tx
// - Every carrier detect edge flagged; level readable
// - Full receive FIFO drops frame or character
// - Masked events no interrupt; visible only optionally
module sces_event_status
	import sces_pkg::*;
#(
	parameter int unsigned CHAN_IDX = 0
) (
	input  wire logic              mclk_i,
	input  wire logic              rst_b_i,
	input  wire sces_cfg_t         cfg_i,
	input  wire logic [31:0]       event_mask_reg_i,
	input  wire logic              rd_en_i,
	input  wire logic [ADDR_W-1:0] rd_addr_i,
	input  wire logic              bit_tick_i,
	input  wire logic              rx_line_i,
	input  wire sces_rx_char_t     rx_char_i,
	input  wire logic              rx_fifo_full_i,
	input  wire logic              rx_frame_begin_i,
	input  wire logic              rx_frame_byte_i,
	input  wire logic              rx_frame_done_i,
	input  wire logic              rx_addr_match_i,
	input  wire logic              rx_open_flag_i,
	input  wire logic              rx_remote_ready_i,
	input  wire logic              rx_remote_valid_i,
	input  wire logic              rx_nr_error_i,
	input  wire logic              rx_s_with_i_i,
	input  wire logic              rx_len_abort_i,
	input  wire logic              sync_match_i,
	input  wire logic              hunt_cmd_i,
	input  wire logic              tx_last_bit_i,
	input  wire logic              tx_iframe_acked_i,
	input  wire logic              tx_ack_timeout_i,
	input  wire logic              tx_nak_i,
	input  wire logic              tx_collision_i,
	input  wire logic              tx_char_done_i,
	input  wire logic              tx_byte_sent_i,
	input  wire logic              tx_frame_begin_i,
	input  wire logic              tx_active_i,
	input  wire logic              tx_fifo_empty_i,
	input  wire logic              tx_end_marker_i,
	input  wire logic              tx_clk_ok_i,
	input  wire logic              transmitter_reset_cmd_i,
	input  wire logic              timer_expire_i,
	input  wire logic              cts_b_i,
	input  wire logic              cd_i,
	input  wire logic              clock_recovery_loop_locked_i,
	output logic [31:0]            rd_data_o,
	output logic                   int_req_o,
	output logic                   tx_halted_o,
	output logic                   tx_close_req_o,
	output logic                   tx_paused_o,
	output logic                   rx_blocked_o,
	output logic                   rx_discard_o,
	output logic                   rx_frame_end_push_o,
	output logic                   rx_ovf_mark_o,
	output logic                   rx_char_parity_err_o,
	output logic                   cts_level_o,
	output logic                   cd_level_o,
	output logic                   remote_ready_state_o
);
	logic        is_frame;
	logic        is_async;
	logic        is_bsync;
	logic [31:0] evt;
	logic [31:0] status;
	logic [31:0] next_status;
	logic        rd_hit;
	logic        cts_q;
	logic        cd_q;
	logic        lock_q;
	logic        tx_halt;
	logic        pool_pend;
	logic        flow_paused;
	logic [2:0]  sent_bytes;
	logic [4:0]  low_cnt;
	logic        brk_on;
	logic [7:0]  idle_cnt;
	logic        to_armed;
	logic        hunting;
	logic        rx_drop_frame;
	logic        underrun;
	logic        brk_hit;
	logic        to_hit;
	logic        par_bad;
	logic [4:0]  brk_len;

	assign is_frame = (cfg_i.mode == SCES_FRAME);
	assign is_async = (cfg_i.mode == SCES_ASYNC);
	assign is_bsync = (cfg_i.mode == SCES_BSYNC);
	assign rd_hit   = rd_en_i && (rd_addr_i == CHAN_STATUS_OFS[CHAN_IDX]);
	assign underrun = (is_frame || is_bsync) && tx_active_i && !tx_halt && tx_fifo_empty_i && !tx_end_marker_i;
	assign brk_len  = 5'(cfg_i.char_bits) + 5'(cfg_i.parity_enable) + 5'(cfg_i.stop_bits);
	assign brk_hit  = is_async && !brk_on && bit_tick_i && !rx_line_i && (low_cnt + 5'h01 >= brk_len);
	assign to_hit   = is_async && cfg_i.timeout_enable && to_armed && bit_tick_i
		&& (idle_cnt + 8'h01 >= cfg_i.timeout_length);
	assign par_bad  = rx_char_i.valid && (is_async || is_bsync) && cfg_i.parity_enable
		&& ((^rx_char_i.data) ^ rx_char_i.parity_bit ^ cfg_i.parity_odd);

	// ==========================================================
	// Event vector
	always_comb begin
		evt = 32'h0000_0000;
		if (is_frame) begin
			evt[B_ALL_SENT] = tx_last_bit_i || (cfg_i.auto_mode && (tx_iframe_acked_i || tx_ack_timeout_i));
		end else begin
			evt[B_ALL_SENT] = tx_char_done_i && tx_fifo_empty_i;
		end
		evt[B_UNDERRUN] = underrun;
		if (is_async && rx_char_i.valid) begin
			evt[B_PAUSE_CHAR] = (rx_char_i.data == cfg_i.pause_char);
			evt[B_RESUME_CHR] = (rx_char_i.data == cfg_i.resume_char);
		end
		evt[B_TIMER] = timer_expire_i;
		evt[B_CTS_CHANGE] = (cts_b_i != cts_q);
		if (!is_async && sent_bytes >= BYTES_FOR_RETX) begin
			evt[B_RETRANSMIT] = (cts_b_i && !cts_q)
				|| (is_frame && (tx_collision_i || (cfg_i.auto_mode && tx_nak_i)));
		end
		// pool ready once reset done and clock present
		evt[B_POOL_READY] = pool_pend && tx_clk_ok_i;
		evt[B_BREAK]     = brk_hit;
		evt[B_BREAK_END] = is_async && brk_on && rx_line_i;
		if (is_frame) begin
			evt[B_RX_OVERRUN] = rx_frame_byte_i && rx_fifo_full_i && !rx_drop_frame;
		end else begin
			evt[B_RX_OVERRUN] = rx_char_i.valid && (rx_char_i.data == cfg_i.term_char);
		end
		if (is_frame) begin
			evt[B_FRAME_STRT] = cfg_i.addr_recog ? rx_addr_match_i : rx_open_flag_i;
		end else if (is_async) begin
			evt[B_TIMEOUT] = to_hit;
		end
		if (is_frame) begin
			evt[B_REMOTE_CHG] = cfg_i.auto_mode && rx_remote_valid_i && (rx_remote_ready_i != remote_ready_state_o);
		end else begin
			evt[B_PARITY] = par_bad;
		end
		case (cfg_i.mode)
			SCES_FRAME: evt[B_PROTOCOL] = cfg_i.auto_mode && (rx_nr_error_i || rx_s_with_i_i);
			SCES_ASYNC: evt[B_FRAMING]  = rx_char_i.valid && !rx_char_i.stop_bit;
			default:    evt[B_SYNC_PAT] = hunting && sync_match_i;
		endcase
		evt[B_UNLOCK] = lock_q && !clock_recovery_loop_locked_i;
		evt[B_CARRIER] = (cd_i != cd_q);
		if (is_frame) begin
			evt[B_FIFO_OVF] = rx_frame_begin_i && rx_fifo_full_i;
		end else begin
			evt[B_FIFO_OVF] = rx_char_i.valid && rx_fifo_full_i;
		end
		evt[B_TOO_LONG] = is_frame && cfg_i.length_check && rx_len_abort_i;
	end

	// ==========================================================
	// Status register, masking and read port
	always_comb begin
		// masked events hidden unless the visibility option is set
		// set wins over the collecting read
		next_status = (rd_hit ? STATUS_RST : status)
			| (evt & (~event_mask_reg_i | {32{cfg_i.masked_visible_option}}));
	end

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			status    <= STATUS_RST;
			rd_data_o <= READ_UNMAPPED;
			int_req_o <= 1'b0;
		end else begin
			status    <= next_status;
			rd_data_o <= rd_hit ? status : READ_UNMAPPED;
			// only unmasked flags raise the request
			int_req_o <= |(next_status & ~event_mask_reg_i);
		end
	end

	// ==========================================================
	// Line level trackers
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cts_q  <= 1'b1;
			cd_q   <= 1'b0;
			lock_q <= 1'b0;
		end else begin
			cts_q  <= cts_b_i;
			cd_q   <= cd_i;
			lock_q <= clock_recovery_loop_locked_i;
		end
	end
	assign cts_level_o = cts_q;
	assign cd_level_o  = cd_q;

	// ==========================================================
	// Transmitter control
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			tx_halt        <= 1'b0;
			tx_close_req_o <= 1'b0;
			pool_pend      <= 1'b0;
			flow_paused    <= 1'b0;
			sent_bytes     <= 3'h0;
		end else begin
			// halt holds until the reset command
			tx_close_req_o <= underrun;
			if (transmitter_reset_cmd_i) begin
				tx_halt <= 1'b0;
			end else if (underrun) begin
				tx_halt <= 1'b1;
			end
			// held pending while no transmit clock
			if (transmitter_reset_cmd_i) begin
				pool_pend <= 1'b1;
			end else if (tx_clk_ok_i) begin
				pool_pend <= 1'b0;
			end
			if (!cfg_i.inband_flow_enable || !is_async || transmitter_reset_cmd_i) begin
				flow_paused <= 1'b0;
			end else if (evt[B_PAUSE_CHAR]) begin
				flow_paused <= 1'b1;
			end else if (evt[B_RESUME_CHR]) begin
				flow_paused <= 1'b0;
			end
			// count sent bytes of the current frame or block
			if (tx_frame_begin_i) begin
				sent_bytes <= 3'h0;
			end else if (tx_byte_sent_i && sent_bytes < BYTES_FOR_RETX) begin
				sent_bytes <= sent_bytes + 3'h1;
			end
		end
	end
	assign tx_halted_o = tx_halt;

	// pause transmit clocked from the lost loop
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			tx_paused_o  <= 1'b0;
			rx_blocked_o <= 1'b1;
		end else begin
			tx_paused_o  <= flow_paused || (cfg_i.tx_from_clock_recovery_loop && !clock_recovery_loop_locked_i);
			rx_blocked_o <= !clock_recovery_loop_locked_i;
		end
	end

	// ==========================================================
	// Receive line supervision
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			low_cnt  <= 5'h00;
			brk_on   <= 1'b0;
			idle_cnt <= 8'h00;
			to_armed <= 1'b0;
		end else begin
			// count low bit times; break ends on the rising line
			if (rx_line_i || !is_async) begin
				low_cnt <= 5'h00;
			end else if (bit_tick_i && !brk_on) begin
				low_cnt <= low_cnt + 5'h01;
			end
			if (evt[B_BREAK_END] || !is_async) begin
				brk_on <= 1'b0;
			end else if (brk_hit) begin
				brk_on <= 1'b1;
			end
			// one timeout per silence, re-armed by a character
			if (rx_char_i.valid) begin
				idle_cnt <= 8'h00;
				to_armed <= 1'b1;
			end else if (to_hit) begin
				to_armed <= 1'b0;
			end else if (bit_tick_i && to_armed) begin
				idle_cnt <= idle_cnt + 8'h01;
			end
		end
	end

	// ==========================================================
	// Receive data path effects
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			hunting              <= 1'b0;
			rx_drop_frame        <= 1'b0;
			rx_discard_o         <= 1'b0;
			rx_frame_end_push_o  <= 1'b0;
			rx_ovf_mark_o        <= 1'b0;
			rx_char_parity_err_o <= 1'b0;
			remote_ready_state_o <= 1'b1;
		end else begin
			// hunt until the pattern is found
			if (hunt_cmd_i) begin
				hunting <= 1'b1;
			end else if (evt[B_SYNC_PAT] && is_bsync) begin
				hunting <= 1'b0;
			end
			// whole frame dropped when full at its start
			if (evt[B_FIFO_OVF] && is_frame) begin
				rx_drop_frame <= 1'b1;
			end else if (rx_frame_done_i) begin
				rx_drop_frame <= 1'b0;
			end
			// drop while full or while the frame is dropped; otherwise resume when space frees
			rx_discard_o <= (rx_frame_byte_i && (rx_fifo_full_i || rx_drop_frame))
				|| (!is_frame && rx_char_i.valid && rx_fifo_full_i);
			// overflow mark carried into the frame status byte
			if (rx_frame_begin_i) begin
				rx_ovf_mark_o <= 1'b0;
			end else if (evt[B_RX_OVERRUN] && is_frame) begin
				rx_ovf_mark_o <= 1'b1;
			end
			rx_frame_end_push_o <= !is_frame && evt[B_TERM_CHAR];
			rx_char_parity_err_o <= par_bad && cfg_i.per_char_status_enable;
			if (is_frame && cfg_i.auto_mode && rx_remote_valid_i) begin
				remote_ready_state_o <= rx_remote_ready_i;
			end
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_b_i);

	chk_cts_edge_flag: assert property ((cts_b_i != cts_q) && !event_mask_reg_i[B_CTS_CHANGE]
		|=> status[B_CTS_CHANGE]) else $error("CTS edge not flagged");
	chk_carrier_edge: assert property ($changed(cd_i) && !event_mask_reg_i[B_CARRIER]
		|=> status[B_CARRIER] && cd_level_o == $past(cd_i)) else $error("Carrier edge not flagged");
	chk_halt_until_reset: assert property (tx_halted_o && !transmitter_reset_cmd_i
		|=> tx_halted_o) else $error("Transmitter left halt without reset");
	chk_underrun_halts: assert property (underrun && !transmitter_reset_cmd_i
		|=> tx_halted_o && tx_close_req_o) else $error("Underrun did not halt");
	chk_masked_no_int: assert property ((status & ~event_mask_reg_i) == 32'h0
		&& $stable(event_mask_reg_i) |=> !int_req_o || $changed(status)) else $error("Masked interrupt raised");
	chk_hidden_masked: assert property (!cfg_i.masked_visible_option && $stable(event_mask_reg_i)
		&& !rd_hit ##1 $stable(event_mask_reg_i) |-> ((status & ~$past(status)) & event_mask_reg_i) == 32'h0)
		else $error("Masked event shown");
	chk_flag_sticky: assert property (status[B_TIMER] && !rd_hit |=> status[B_TIMER])
		else $error("Flag lost before collection");
	chk_set_beats_read: assert property (rd_hit && timer_expire_i && !event_mask_reg_i[B_TIMER]
		|=> status[B_TIMER]) else $error("Timer event lost on read");
	chk_pool_clock: assert property (pool_pend && !tx_clk_ok_i && !event_mask_reg_i[B_POOL_READY]
		&& !status[B_POOL_READY] |=> !status[B_POOL_READY]) else $error("Pool ready without clock");
	chk_term_push: assert property (is_async && rx_char_i.valid && rx_char_i.data == cfg_i.term_char
		|=> rx_frame_end_push_o) else $error("No frame end pushed");
	chk_unlock_block: assert property (lock_q && !clock_recovery_loop_locked_i
		|=> rx_blocked_o && (tx_paused_o || !$past(cfg_i.tx_from_clock_recovery_loop))) else $error("Unlock not blocking");
	chk_hunt_only: assert property (is_bsync && !hunting && !event_mask_reg_i[B_SYNC_PAT]
		&& !status[B_SYNC_PAT] && !hunt_cmd_i |=> !status[B_SYNC_PAT]) else $error("Sync flagged outside hunt");

	cov_underrun: cover property (underrun ##1 tx_halted_o ##[1:20] transmitter_reset_cmd_i);
	cov_break_cycle: cover property (brk_hit ##[1:200] evt[B_BREAK_END]);
	cov_retransmit: cover property (evt[B_RETRANSMIT]);
	cov_read_clear: cover property (rd_hit && status != 32'h0);
endmodule // sces_event_status

// file: sim/sces_host_model.sv
// Purpose: Host side model that reads the event status word and owns the mask
// Assumes: One read at a time, requested by the bench
// Notes:   Address is scrambled once released so stale values never look valid
module sces_host_model
	import sces_pkg::*;
(
	input  wire logic              mclk_i,
	output logic                   rd_en_o,
	output logic [ADDR_W-1:0]      rd_addr_o,
	output logic [31:0]            mask_o
);
	timeunit 1ns;
	timeprecision 100ps;
	// ==========================================================
	// Mask register
	// all events masked from reset
	initial begin
		rd_en_o   = 1'b0;
		rd_addr_o = '0;
		mask_o    = 32'hffff_ffff;
	end
	task automatic set_mask(input logic [31:0] m);
		mask_o = m;
	endtask
	// ==========================================================
	// Read cycle: held over exactly one sampling edge
	task automatic rd(input logic [ADDR_W-1:0] a);
		rd_en_o   = 1'b1;
		rd_addr_o = a;
		@(posedge mclk_i);
		#1 rd_en_o = 1'b0;
		rd_addr_o = ~a;
		// Idle edge so back-to-back reads never retoggle the strobe in one step
		@(posedge mclk_i);
		#1;
	endtask
endmodule // sces_host_model

// file: sim/test_serial_channel_event_status.sv
// Purpose: Self-checking bench for the channel event status block
// Assumes: Host model issues reads, bench raises every event flag except the async timeout
// Notes:   Read words are checked against a queue of expected values
module test_serial_channel_event_status
	import sces_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int unsigned CH = 1;
	localparam logic [ADDR_W-1:0] OFS = CHAN_STATUS_OFS[CH];
	logic              mclk_i = 1'b0;
	logic              rst_b_i = 1'b0;
	sces_cfg_t         cfg_i;
	sces_rx_char_t     rx_char_i;
	logic [31:0]       event_mask_reg_i, rd_data_o, exp_q[$];
	logic [ADDR_W-1:0] rd_addr_i;
	logic rd_en_i, bit_tick_i, rx_line_i, rx_fifo_full_i, rx_frame_begin_i, rx_frame_byte_i, rx_frame_done_i;
	logic rx_addr_match_i, rx_open_flag_i, rx_remote_ready_i, rx_remote_valid_i, rx_nr_error_i, rx_s_with_i_i;
	logic rx_len_abort_i, sync_match_i, hunt_cmd_i, tx_last_bit_i, tx_iframe_acked_i, tx_ack_timeout_i;
	logic tx_nak_i, tx_collision_i, tx_char_done_i, tx_byte_sent_i, tx_frame_begin_i, tx_active_i;
	logic tx_fifo_empty_i, tx_end_marker_i, tx_clk_ok_i, transmitter_reset_cmd_i, timer_expire_i;
	logic cts_b_i, cd_i, clock_recovery_loop_locked_i, int_req_o, tx_halted_o, tx_close_req_o, tx_paused_o, rx_blocked_o;
	logic rx_discard_o, rx_frame_end_push_o, rx_ovf_mark_o, rx_char_parity_err_o, cts_level_o, cd_level_o;
	logic remote_ready_state_o;
	logic mon_pend = 1'b0;
	logic [7:0] d;
	int fails = 0, cmp_count = 0, nb = 0, nt = 0, b;
	int seq[$] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 14, 15, 15, 15, 16, 14, 15, 15, 15, 15, 16,
		17, 18, 19, 20, 21, 22, 23, 23, 23, 23, 23, 23, 23, 23, 23, 24, 25, 26};

	always #5 mclk_i = ~mclk_i;
	sces_event_status #(.CHAN_IDX(CH)) i_sces_event_status (.*);
	sces_host_model i_sces_host_model (.mclk_i(mclk_i), .rd_en_o(rd_en_i), .rd_addr_o(rd_addr_i),
		.mask_o(event_mask_reg_i));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic summarize();
		$display("Checks %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic rd(input logic [31:0] e, input logic [ADDR_W-1:0] a = OFS);
		exp_q.push_back(e);
		i_sces_host_model.rd(a);
	endtask
	task automatic clr();
		{bit_tick_i, rx_fifo_full_i, rx_frame_begin_i, rx_frame_byte_i, rx_frame_done_i, rx_addr_match_i} = '0;
		{rx_open_flag_i, rx_remote_valid_i, rx_nr_error_i, rx_s_with_i_i, rx_len_abort_i, sync_match_i} = '0;
		{hunt_cmd_i, tx_last_bit_i, tx_iframe_acked_i, tx_ack_timeout_i, tx_nak_i, tx_collision_i} = '0;
		{tx_char_done_i, tx_byte_sent_i, tx_frame_begin_i, tx_active_i, tx_fifo_empty_i, tx_end_marker_i} = '0;
		{transmitter_reset_cmd_i, timer_expire_i, rx_char_i.valid} = '0;
	endtask
	// One event source per code; b is the status bit it must set
	task automatic fire(input int k);
		b = -1;
		case (k)
			0: begin timer_expire_i = 1'b1; b = B_TIMER; end
			1: begin tx_last_bit_i = 1'b1; b = B_ALL_SENT; end
			2: begin rx_open_flag_i = 1'b1; b = B_FRAME_STRT; end
			3: begin cfg_i.length_check = 1'b1; rx_len_abort_i = 1'b1; b = B_TOO_LONG; end
			4: begin cfg_i.auto_mode = 1'b1; rx_nr_error_i = 1'b1; b = B_PROTOCOL; end
			5: begin rx_s_with_i_i = 1'b1; b = B_PROTOCOL; end
			6: begin tx_iframe_acked_i = 1'b1; b = B_ALL_SENT; end
			7: begin tx_ack_timeout_i = 1'b1; b = B_ALL_SENT; end
			8: begin rx_remote_ready_i = 1'b0; rx_remote_valid_i = 1'b1; b = B_REMOTE_CHG; end
			9: begin rx_fifo_full_i = 1'b1; rx_frame_begin_i = 1'b1; b = B_FIFO_OVF; end
			10: begin cfg_i.mode = SCES_ASYNC; tx_fifo_empty_i = 1'b1; tx_char_done_i = 1'b1; b = B_ALL_SENT; end
			11: begin cfg_i.mode = SCES_BSYNC; hunt_cmd_i = 1'b1; end
			12: begin sync_match_i = 1'b1; b = B_SYNC_PAT; end
			13: begin cfg_i.mode = SCES_ASYNC; rx_char_i = '{1'b1, cfg_i.term_char, 1'b0, 1'b1}; b = B_TERM_CHAR; end
			14: begin cfg_i.mode = SCES_FRAME; cfg_i.auto_mode = 1'b0; tx_frame_begin_i = 1'b1; nb = 0; end
			15: begin tx_byte_sent_i = 1'b1; nb++; end
			16: begin tx_collision_i = 1'b1; b = (nb >= 4) ? B_RETRANSMIT : -1; end
			17: begin cfg_i.mode = SCES_ASYNC; cfg_i.inband_flow_enable = 1'b1;
				rx_char_i = '{1'b1, cfg_i.pause_char, 1'b0, 1'b1}; b = B_PAUSE_CHAR; end
			18: begin rx_char_i = '{1'b1, cfg_i.resume_char, 1'b0, 1'b1}; b = B_RESUME_CHR; end
			19: begin cfg_i.parity_enable = 1'b1; d = {1'b1, 7'($urandom)}; rx_char_i = '{1'b1, d, ~^d, 1'b1};
				cfg_i.per_char_status_enable = 1'b1; b = B_PARITY; end
			20: begin cfg_i.parity_enable = 1'b0; rx_char_i = '{1'b1, 8'h80, 1'b0, 1'b0}; b = B_FRAMING; end
			21: begin cd_i = ~cd_i; b = B_CARRIER; end
			22: begin cts_b_i = ~cts_b_i; b = B_CTS_CHANGE; end
			23: begin rx_line_i = 1'b0; bit_tick_i = 1'b1; nt++;
				if (nt == 32'(cfg_i.char_bits) + 32'(cfg_i.stop_bits)) b = B_BREAK; end
			24: begin rx_line_i = 1'b1; b = B_BREAK_END; end
			25: begin cfg_i.mode = SCES_FRAME; cfg_i.addr_recog = 1'b1; rx_addr_match_i = 1'b1; b = B_FRAME_STRT; end
			26: begin clock_recovery_loop_locked_i = 1'b0; b = B_UNLOCK; end
			default: b = -1;
		endcase
	endtask
	task automatic ev(input int k, input logic msk);
		fire(k);
		@(posedge mclk_i);
		#1 clr();
		chk(rx_frame_end_push_o, k == 13);
		chk(rx_char_parity_err_o, k == 19);
		@(posedge mclk_i);
		#1 chk(int_req_o, !msk && b >= 0);
		chk(tx_paused_o, k == 17);
		rd((b >= 0 && (!msk || cfg_i.masked_visible_option)) ? 32'h1 << b : 32'h0);
		rd(32'h0);
	endtask

	// ==========================================================
	// Read monitor
	always @(posedge mclk_i) mon_pend <= rd_en_i;
	always @(negedge mclk_i) if (mon_pend) chk(rd_data_o, exp_q.pop_front());

	initial begin
		#500us;
		fails++;
		summarize();
	end

	initial begin
		b = $urandom(32'hc941);
		cfg_i = '0;
		cfg_i.char_bits = 4'h8;
		cfg_i.stop_bits = 2'h1;
		{cfg_i.pause_char, cfg_i.resume_char, cfg_i.term_char} = {8'h13, 8'h11, 8'h0d};
		rx_char_i = '0;
		clr();
		// Transmit clock absent until the pool ready test supplies it
		{rx_line_i, cts_b_i, cd_i, clock_recovery_loop_locked_i, rx_remote_ready_i, tx_clk_ok_i} = 6'h3e;
		repeat (8) @(posedge mclk_i);
		#1 chk(rx_blocked_o, 1'b1);
		chk(remote_ready_state_o, 1'b1);
		chk(int_req_o, 1'b0);
		chk(rd_data_o, 32'h0);
		rst_b_i = 1'b1;
		rd(STATUS_RST);
		$display("reset test done");
		ev(0, 1'b1);
		cfg_i.masked_visible_option = 1'b1;
		ev(0, 1'b1);
		cfg_i.masked_visible_option = 1'b0;
		i_sces_host_model.set_mask(32'h0);
		fire(0);
		@(posedge mclk_i);
		#1 clr();
		rd(READ_UNMAPPED, 12'h15c);
		rd(32'h1 << B_TIMER);
		$display("mask test done");
		foreach (seq[i]) ev(seq[i], 1'b0);
		chk(rx_blocked_o, 1'b1);
		chk(cts_level_o, 1'b0);
		chk(cd_level_o, 1'b0);
		chk(remote_ready_state_o, 1'b0);
		clock_recovery_loop_locked_i = 1'b1;
		repeat (2) @(posedge mclk_i);
		#1 chk(rx_blocked_o, 1'b0);
		// Frame dropped since the full-at-start event: bytes discarded until it ends
		rx_frame_byte_i = 1'b1;
		@(posedge mclk_i);
		#1 clr();
		chk(rx_discard_o, 1'b1);
		rx_frame_done_i = 1'b1;
		@(posedge mclk_i);
		#1 clr();
		{rx_fifo_full_i, rx_frame_byte_i} = 2'h3;
		@(posedge mclk_i);
		#1 clr();
		chk(rx_ovf_mark_o, 1'b1);
		rd(32'h1 << B_RX_OVERRUN);
		$display("event test done");
		{tx_active_i, tx_fifo_empty_i} = 2'h3;
		@(posedge mclk_i);
		#1 clr();
		chk({tx_halted_o, tx_close_req_o}, 2'h3);
		@(posedge mclk_i);
		#1 chk({tx_halted_o, tx_close_req_o}, 2'h2);
		rd(32'h1 << B_UNDERRUN);
		transmitter_reset_cmd_i = 1'b1;
		@(posedge mclk_i);
		#1 clr();
		@(posedge mclk_i);
		#1 chk(tx_halted_o, 1'b0);
		rd(32'h0);
		tx_clk_ok_i = 1'b1;
		repeat (2) @(posedge mclk_i);
		#1 rd(32'h1 << B_POOL_READY);
		repeat (2) @(posedge mclk_i);
		$display("underrun test done");
		summarize();
	end
endmodule // test_serial_channel_event_status
